// ==== sdmc_checker.sv ====
// link protocol assertions for the sigma-delta mode control
module sdmc_checker
	import sdmc_pkg::*;
(
	input wire logic               core_clk,              // clock
	input wire logic               rst,                   // sync reset
	input wire logic [NOTCH_W-1:0] notch_code,            // notch code
	input wire sdmc_mode_t         operating_mode_select, // mode field
	input wire logic               mode_wr,               // mode write pulse
	input wire logic               coef_wr,               // coef write pulse
	input wire logic [1:0]         coef_sel,              // coef select
	input wire logic               data_ready_n,          // ready, active low
	input wire logic               result_stb,            // word strobe
	input wire logic [WORD_W-1:0]  result,                // output word
	input wire logic [WORD_W-1:0]  off_coef,              // offset coef
	input wire logic [WORD_W-1:0]  pos_coef,              // plus slope
	input wire logic [WORD_W-1:0]  neg_coef               // minus slope
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking dc @(posedge core_clk); endclocking
	default disable iff (rst);
	sdmc_mode_t  mode_q;
	logic [26:0] per_q;
	logic [26:0] cnt_q;
	logic [26:0] gap_q;
	logic [26:0] req;
	logic [3:0]  nper;
	logic        gap_ok_q;
	logic        zero_q;
	logic        pend_q;
	// mode and period latched at each mode write
	always_ff @(posedge core_clk) begin
		if (rst) begin
			mode_q <= MODE_CONV;
			per_q  <= 27'h1400;
		end else if (mode_wr) begin
			mode_q <= operating_mode_select;
			per_q  <= {7'h0, notch_code, 9'h0};
		end
	end
	always_ff @(posedge core_clk) begin
		cnt_q <= (rst || mode_wr) ? 27'h0 : cnt_q + 27'h1;
	end
	always_ff @(posedge core_clk) begin
		gap_q <= (rst || mode_wr || result_stb) ? 27'h0 : gap_q + 27'h1;
	end
	always_ff @(posedge core_clk) begin
		gap_ok_q <= (rst || mode_wr) ? 1'b0 : (gap_ok_q || result_stb);
	end
	always_ff @(posedge core_clk) begin
		pend_q <= (rst || mode_wr) ? 1'b0 : (pend_q || coef_wr);
	end
	always_ff @(posedge core_clk) begin
		if (rst) begin
			zero_q <= 1'b0;
		end else if (coef_wr && coef_sel == COEF_OFF) begin
			zero_q <= 1'b1;
		end else if (mode_wr && operating_mode_select inside {MODE_SELF, MODE_SOFF, MODE_SOIG}) begin
			zero_q <= 1'b1;
		end
	end
	always_comb begin
		case (mode_q)
			MODE_CONV: nper = 4'h3;
			MODE_SOFF, MODE_SPFS, MODE_SNFS: nper = 4'h4;
			MODE_SELF, MODE_SOIG: nper = 4'hC;
			MODE_SGAIN: nper = 4'h7;
			default: nper = 4'hF;
		endcase
	end
	assign req = per_q * {23'h0, nper};

	chk_ready_rise: assert property (mode_wr |=> data_ready_n)
		else $error("ready not raised after mode write");
	chk_settle_time: assert property ($fell(data_ready_n) |-> cnt_q + 27'h2 >= req && cnt_q <= req + 27'h8)
		else $error("ready fell at wrong time for the mode");
	chk_ready_word: assert property ($fell(data_ready_n) |-> result_stb)
		else $error("ready fell without a word");
	chk_ready_held: assert property (!data_ready_n && !mode_wr |=> !data_ready_n)
		else $error("ready released without a mode write");
	chk_word_spacing: assert property (result_stb && gap_ok_q && mode_q == MODE_CONV |-> gap_q == per_q - 27'h1)
		else $error("word spacing differs from notch period");
	chk_result_hold: assert property ($changed(result) |-> result_stb)
		else $error("result changed without strobe");
	chk_rsvd_silent: assert property (mode_q == MODE_RSVD && !mode_wr |-> !result_stb && data_ready_n)
		else $error("reserved mode produced output");
	chk_notch_floor: assert property (mode_wr |-> notch_code >= NOTCH_MIN)
		else $error("notch code below usable range");
	chk_zero_first: assert property (mode_wr && operating_mode_select inside {MODE_SPFS, MODE_SNFS, MODE_SGAIN} |-> zero_q)
		else $error("full scale calibration before zero scale");
	chk_conv_no_cal: assert property ($changed({off_coef, pos_coef, neg_coef}) && mode_q == MODE_CONV |-> pend_q)
		else $error("coefficients changed in conversion mode");
endmodule

// ==== sdmc_dev_end.sv ====
// converter end: decimation filter, calibration and conversion controller
//
// Contract
// - modulator bit rate is clock over 128
// - 40-bit sinc3 decimator, no multipliers
// - 11-bit code sets ratio, notch clock/(512*code)
// - one output word per notch period
// - host keeps code within 10..2047
// - datapath headroom beyond full scale
// - step settles within three to four periods
// - no rejection at modulator rate multiples
// - all timing scales with master clock
// - 3-bit field selects conversion or calibrations
// - host picks self modes only at gain one
// - ready low when calibration done, data valid
// - conversion mode waits three periods first
// - conversion mode uses stored coefficients only
// - calibrate zero, plus and minus full scale
// - host calibrates zero before full scale
// - zero offset, 800000 slopes mean uncalibrated
// - host recalibrates after gain or notch change (host end only sets the stale flag)
// - self calibration steps of three periods
// - single system steps ready after four periods
// - gain calibration: negative, reversed positive, one
// - coefficient writes effective by second word
//
// The APB interface to the registers and the address map were decided locally.
module sdmc_dev_end
	import sdmc_pkg::*;
(
	input  wire logic   core_clk,   // master clock
	input  wire logic   rst,        // synchronous reset, active high
	sdmc_link_if.dev_mp link,       // link to host end
	input  wire logic   mod_bit_in, // one-bit modulator stream
	output sdmc_fsel_t  front_sel   // front-end input routing
);
	typedef enum logic [3:0] {
		ST_SETTLE = 4'b0000,
		ST_RUN    = 4'b0001,
		ST_OFF    = 4'b0011,
		ST_PFS    = 4'b0010,
		ST_NFS    = 4'b0110,
		ST_FINAL  = 4'b0111,
		ST_ONE    = 4'b0101,
		ST_GNEG   = 4'b0100,
		ST_GPOS   = 4'b1100,
		ST_HOLD   = 4'b1101
	} sdmc_state_t;

	function automatic logic [4:0] scale_shift(input logic [DEC_W-1:0] r);
		int n;
		int s;
		n = 0;
		for (int i = 0; i < DEC_W; i++) begin
			if (r > DEC_W'(1 << i)) begin
				n = i + 1;
			end
		end
		s = 3 * n - SCALE_W;
		return (s > 0) ? 5'(s) : 5'h00;
	endfunction

	// slope in Q23 from measured span against nominal full scale
	function automatic logic [WORD_W-1:0] gain_slope(input logic signed [WORD_W:0] meas);
		logic signed [WORD_W+2:0] s;
		s = 27'sh080_0000 + ((27'(signed'({1'b0, FS_NOM})) - 27'(meas)) <<< 1);
		if (s < 0) begin
			return 24'h00_0000;
		end
		if (s > 27'sh0FF_FFFF) begin
			return 24'hFF_FFFF;
		end
		return s[WORD_W-1:0];
	endfunction

	logic                    mod_meta_q;
	logic                    mod_sync_q;
	logic [DIV_W-1:0]        div_q;
	logic [DEC_W-1:0]        dec_cnt_q;
	logic [NOTCH_W-1:0]      notch_q;
	logic signed [ACC_W-1:0] i1_q, i2_q, i3_q, d1_q, d2_q, d3_q, raw_q;
	logic signed [ACC_W-1:0] c1, c2, c3, samp, shifted;
	logic                    dec_stb_q;
	sdmc_state_t             state_q;
	sdmc_mode_t              mode_q;
	logic [2:0]              cnt_q;
	sdmc_fsel_t              fsel_q;
	logic [WORD_W-1:0]       off_q, pos_q, neg_q;
	logic [WORD_W-1:0]       shadow_q [3];
	logic [2:0]              pend_q;
	logic [WORD_W-1:0]       result_q;
	logic                    result_stb_q;
	logic                    data_ready_n_n_q;
	logic [DEC_W-1:0]        ratio;
	logic                    mod_stb, dec_last, period_last, publish;
	logic signed [WORD_W-1:0] raw24;
	logic signed [WORD_W:0]  corr;
	logic signed [49:0]      prod;
	logic signed [26:0]      scaled;
	logic [WORD_W-1:0]       word;
	logic                    cal_off_we, cal_pos_we, cal_neg_we;
	logic [WORD_W-1:0]       cal_pos_val;

	always_ff @(posedge core_clk) begin
		mod_meta_q <= mod_bit_in;
		mod_sync_q <= mod_meta_q;
	end

	// modulator rate, phase restarts on mode write
	always_ff @(posedge core_clk) begin
		if (rst || link.mode_wr) begin
			div_q <= '0;
		end else begin
			div_q <= div_q + 7'h01;
		end
	end
	assign mod_stb = (div_q == DIV_LAST);

	assign ratio    = {notch_q, 2'b00};
	assign dec_last = (dec_cnt_q == ratio - 13'h0001);

	always_ff @(posedge core_clk) begin
		if (rst) begin
			notch_q <= NOTCH_MIN;
		end else if (link.mode_wr) begin
			notch_q <= link.notch_code;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst || link.mode_wr) begin
			dec_cnt_q <= '0;
		end else if (mod_stb) begin
			dec_cnt_q <= dec_last ? '0 : dec_cnt_q + 13'h0001;
		end
	end

	assign samp = mod_sync_q ? 40'sh00_0000_0001 : -40'sh00_0000_0001;
	assign c1   = i3_q - d1_q;
	assign c2   = c1 - d2_q;
	assign c3   = c2 - d3_q;

	always_ff @(posedge core_clk) begin
		if (rst || link.mode_wr) begin
			{i1_q, i2_q, i3_q} <= '0;
			{d1_q, d2_q, d3_q} <= '0;
			raw_q <= '0;
		end else if (mod_stb) begin
			i1_q <= i1_q + samp;
			i2_q <= i2_q + i1_q;
			i3_q <= i3_q + i2_q;
			if (dec_last) begin
				d1_q  <= i3_q;
				d2_q  <= c1;
				d3_q  <= c2;
				raw_q <= c3;
			end
		end
	end

	// one word strobe per notch period
	always_ff @(posedge core_clk) begin
		if (rst || link.mode_wr) begin
			dec_stb_q <= 1'b0;
		end else begin
			dec_stb_q <= mod_stb && dec_last;
		end
	end

	// full scale at 2^22 leaves 2x range in 24 bits
	assign shifted = raw_q >>> scale_shift(ratio);
	assign raw24   = shifted[WORD_W-1:0];
	assign corr    = 25'(raw24) - 25'(signed'(off_q));
	assign prod    = 50'(corr) * 50'(signed'({1'b0, (corr < 0) ? neg_q : pos_q}));
	assign scaled  = prod[49:SLOPE_Q];

	always_comb begin
		if (scaled > 27'sh07F_FFFF) begin
			word = 24'hFF_FFFF;
		end else if (scaled < -27'sh080_0000) begin
			word = 24'h00_0000;
		end else begin
			word = scaled[WORD_W-1:0] ^ MID_CODE;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			state_q <= ST_SETTLE;
			mode_q  <= MODE_CONV;
			cnt_q   <= SETTLE_PER;
			fsel_q  <= FSEL_INPUT;
		end else if (link.mode_wr) begin
			mode_q <= link.operating_mode_select;
			fsel_q <= FSEL_INPUT;
			case (link.operating_mode_select)
				MODE_CONV: begin
					state_q <= ST_SETTLE;
					cnt_q   <= SETTLE_PER;
				end
				MODE_SELF: begin
					state_q <= ST_OFF;
					cnt_q   <= CAL_PER;
					fsel_q  <= FSEL_SHORT;
				end
				MODE_SOFF, MODE_SPFS, MODE_SNFS: begin
					state_q <= ST_ONE;
					cnt_q   <= SYS_PER;
				end
				MODE_SOIG: begin
					state_q <= ST_OFF;
					cnt_q   <= CAL_PER;
				end
				MODE_SGAIN: begin
					state_q <= ST_GNEG;
					cnt_q   <= CAL_PER;
				end
				default: begin
					state_q <= ST_HOLD;
					cnt_q   <= TAIL_PER;
				end
			endcase
		end else if (dec_stb_q && state_q != ST_RUN && state_q != ST_HOLD) begin
			cnt_q <= cnt_q - 3'h1;
			if (cnt_q == 3'h1) begin
				case (state_q)
					ST_OFF: begin
						state_q <= ST_PFS;
						cnt_q   <= CAL_PER;
						fsel_q  <= FSEL_REFP;
					end
					ST_PFS: begin
						state_q <= ST_NFS;
						cnt_q   <= CAL_PER;
						fsel_q  <= FSEL_REFN;
					end
					ST_NFS: begin
						state_q <= ST_FINAL;
						cnt_q   <= CAL_PER;
						fsel_q  <= FSEL_INPUT;
					end
					ST_GNEG: begin
						state_q <= ST_GPOS;
						cnt_q   <= CAL_PER;
						fsel_q  <= FSEL_INREV;
					end
					ST_GPOS: begin
						state_q <= ST_FINAL;
						cnt_q   <= TAIL_PER;
						fsel_q  <= FSEL_INPUT;
					end
					default: begin
						state_q <= ST_RUN;
					end
				endcase
			end
		end
	end

	assign period_last = dec_stb_q && (cnt_q == 3'h1) && !link.mode_wr;
	assign cal_off_we  = period_last && (state_q == ST_OFF || (state_q == ST_ONE && mode_q == MODE_SOFF));
	assign cal_pos_we  = period_last && (state_q == ST_PFS || state_q == ST_GPOS
	                     || (state_q == ST_ONE && mode_q == MODE_SPFS));
	assign cal_neg_we  = period_last && (state_q == ST_NFS || state_q == ST_GNEG
	                     || (state_q == ST_ONE && mode_q == MODE_SNFS));
	assign cal_pos_val = (state_q == ST_GPOS) ? gain_slope(-corr) : gain_slope(corr);

	// reset to unity, host writes applied at next word
	always_ff @(posedge core_clk) begin
		if (rst) begin
			off_q    <= OFF_RST;
			pos_q    <= GAIN_RST;
			neg_q    <= GAIN_RST;
			shadow_q <= '{OFF_RST, GAIN_RST, GAIN_RST};
			pend_q   <= '0;
		end else begin
			if (dec_stb_q) begin
				if (pend_q[COEF_OFF]) off_q <= shadow_q[COEF_OFF];
				if (pend_q[COEF_POS]) pos_q <= shadow_q[COEF_POS];
				if (pend_q[COEF_NEG]) neg_q <= shadow_q[COEF_NEG];
				pend_q <= '0;
			end
			if (link.coef_wr && link.coef_sel <= COEF_NEG) begin
				shadow_q[link.coef_sel] <= link.coef_wdata;
				pend_q[link.coef_sel]   <= 1'b1;
			end
			if (cal_off_we) off_q <= raw24;
			if (cal_pos_we) pos_q <= cal_pos_val;
			if (cal_neg_we) neg_q <= gain_slope(-corr);
		end
	end

	// publish after settling or calibration end
	assign publish = dec_stb_q && (state_q == ST_RUN || (period_last
	                 && (state_q == ST_SETTLE || state_q == ST_FINAL || state_q == ST_ONE)));

	always_ff @(posedge core_clk) begin
		if (rst) begin
			result_q     <= MID_CODE;
			result_stb_q <= 1'b0;
			data_ready_n_n_q     <= 1'b1;
		end else begin
			result_stb_q <= publish && !link.mode_wr;
			if (link.mode_wr) begin
				data_ready_n_n_q <= 1'b1;
			end else if (publish) begin
				data_ready_n_n_q <= 1'b0;
				result_q <= word;
			end
		end
	end

	assign link.data_ready_n = data_ready_n_n_q;
	assign link.result_stb   = result_stb_q;
	assign link.result       = result_q;
	assign link.off_coef     = off_q;
	assign link.pos_coef     = pos_q;
	assign link.neg_coef     = neg_q;
	assign front_sel         = fsel_q;
endmodule

// ==== sdmc_host_end.sv ====
// host end: APB register slave driving the converter link
module sdmc_host_end
	import sdmc_pkg::*;
(
	input  wire logic    core_clk, // system clock
	input  wire logic    rst,      // synchronous reset, active high
	input  wire logic [7:0]  paddr,   // APB address
	input  wire logic    psel,     // APB select
	input  wire logic    penable,  // APB enable
	input  wire logic    pwrite,   // APB direction
	input  wire logic [31:0] pwdata,  // APB write data
	output logic [31:0]  prdata,   // APB read data
	output logic         pready,   // APB ready
	output logic         pslverr,  // APB error
	sdmc_link_if.host_mp link      // link to converter end
);
	logic [NOTCH_W-1:0] notch_q;
	sdmc_mode_t         mode_q;
	logic               unity_q, mode_wr_q, coef_wr_q;
	logic [1:0]         coef_sel_q;
	logic [WORD_W-1:0]  coef_wdata_q, data_q;
	logic               new_q, zero_q, stale_q;
	logic               rdy_q, err_q;
	logic [31:0]        rdata_q;
	logic               acc, done, wr, mapped, unity_w;
	logic [NOTCH_W-1:0] notch_w;
	sdmc_mode_t         mode_w, mode_ok;

	assign acc    = psel && penable;
	assign done   = acc && rdy_q;
	assign wr     = done && pwrite && !err_q;
	assign mapped = (paddr[1:0] == 2'b00) && (paddr <= REG_STATUS);

	// clamp notch code into usable range
	assign notch_w = (pwdata[NOTCH_W-1:0] < NOTCH_MIN) ? NOTCH_MIN : pwdata[NOTCH_W-1:0];
	assign mode_w  = sdmc_mode_t'(pwdata[CTRL_MODE_LSB +: 3]);
	assign unity_w = pwdata[CTRL_UNITY_BIT];

	always_comb begin
		mode_ok = mode_w;
		// self modes only at gain one
		if ((mode_w == MODE_SELF || mode_w == MODE_SOIG) && !unity_w) begin
			mode_ok = MODE_CONV;
		end
		if ((mode_w == MODE_SPFS || mode_w == MODE_SNFS || mode_w == MODE_SGAIN) && !zero_q) begin
			mode_ok = MODE_CONV;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			rdy_q   <= 1'b0;
			err_q   <= 1'b0;
			rdata_q <= '0;
		end else begin
			rdy_q <= acc && !rdy_q;
			if (acc && !rdy_q) begin
				err_q <= !mapped;
				case (paddr)
					REG_CTRL:   rdata_q <= 32'({unity_q, mode_q, 1'b0, notch_q});
					REG_OFF:    rdata_q <= 32'(link.off_coef);
					REG_POS:    rdata_q <= 32'(link.pos_coef);
					REG_NEG:    rdata_q <= 32'(link.neg_coef);
					REG_DATA:   rdata_q <= 32'(data_q);
					REG_STATUS: rdata_q <= 32'({stale_q, zero_q, new_q, !link.data_ready_n});
					default:    rdata_q <= '0;
				endcase
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			notch_q      <= NOTCH_MIN;
			mode_q       <= MODE_CONV;
			unity_q      <= 1'b1;
			mode_wr_q    <= 1'b0;
			coef_wr_q    <= 1'b0;
			coef_sel_q   <= COEF_OFF;
			coef_wdata_q <= OFF_RST;
			zero_q       <= 1'b0;
			stale_q      <= 1'b1;
		end else begin
			mode_wr_q <= wr && paddr == REG_CTRL;
			coef_wr_q <= wr && (paddr == REG_OFF || paddr == REG_POS || paddr == REG_NEG);
			if (wr && paddr == REG_CTRL) begin
				notch_q <= notch_w;
				mode_q  <= mode_ok;
				unity_q <= unity_w;
				if (mode_ok == MODE_SELF || mode_ok == MODE_SOFF || mode_ok == MODE_SOIG) begin
					zero_q <= 1'b1;
				end
				// flag calibration stale on setting change
				if (notch_w != notch_q || unity_w != unity_q) begin
					stale_q <= 1'b1;
				end else if (mode_ok != MODE_CONV && mode_ok != MODE_RSVD) begin
					stale_q <= 1'b0;
				end
			end
			if (wr && (paddr == REG_OFF || paddr == REG_POS || paddr == REG_NEG)) begin
				coef_sel_q   <= paddr[3:2] - 2'h1;
				coef_wdata_q <= pwdata[WORD_W-1:0];
				if (paddr == REG_OFF) begin
					zero_q <= 1'b1;
				end
			end
		end
	end

	// new-data flag: a fresh word beats a read clear
	always_ff @(posedge core_clk) begin
		if (rst) begin
			data_q <= MID_CODE;
			new_q  <= 1'b0;
		end else if (link.result_stb) begin
			data_q <= link.result;
			new_q  <= 1'b1;
		end else if (done && !pwrite && paddr == REG_DATA) begin
			new_q <= 1'b0;
		end
	end

	assign prdata                     = rdata_q;
	assign pready                     = rdy_q;
	assign pslverr                    = err_q;
	assign link.notch_code            = notch_q;
	assign link.operating_mode_select = mode_q;
	assign link.mode_wr               = mode_wr_q;
	assign link.coef_wr               = coef_wr_q;
	assign link.coef_sel              = coef_sel_q;
	assign link.coef_wdata            = coef_wdata_q;
endmodule

// ==== sdmc_link_if.sv ====
// link between the host end and the converter end
interface sdmc_link_if;
	import sdmc_pkg::*;
	logic [NOTCH_W-1:0] notch_code;
	sdmc_mode_t         operating_mode_select;
	logic               mode_wr;
	logic               coef_wr;
	logic [1:0]         coef_sel;
	logic [WORD_W-1:0]  coef_wdata;
	logic               data_ready_n;
	logic               result_stb;
	logic [WORD_W-1:0]  result;
	logic [WORD_W-1:0]  off_coef;
	logic [WORD_W-1:0]  pos_coef;
	logic [WORD_W-1:0]  neg_coef;

	modport dev_mp (
		input  notch_code, operating_mode_select, mode_wr, coef_wr, coef_sel, coef_wdata,
		output data_ready_n, result_stb, result, off_coef, pos_coef, neg_coef
	);
	modport host_mp (
		output notch_code, operating_mode_select, mode_wr, coef_wr, coef_sel, coef_wdata,
		input  data_ready_n, result_stb, result, off_coef, pos_coef, neg_coef
	);
endinterface

// ==== sdmc_pkg.sv ====
// shared constants and types for the sigma-delta mode control block
package sdmc_pkg;
	localparam int MOD_DIV = 128;
	localparam int DIV_W   = 7;
	localparam int NOTCH_W = 11;
	localparam int DEC_W   = 13;
	localparam int ACC_W   = 40;
	localparam int WORD_W  = 24;
	localparam int SCALE_W = 22;
	localparam int SLOPE_Q = 23;

	localparam logic [DIV_W-1:0]   DIV_LAST  = 7'h7F;
	localparam logic [NOTCH_W-1:0] NOTCH_MIN = 11'h00A;
	localparam logic [NOTCH_W-1:0] NOTCH_MAX = 11'h7FF;
	localparam logic [WORD_W-1:0]  OFF_RST   = 24'h00_0000;
	localparam logic [WORD_W-1:0]  GAIN_RST  = 24'h80_0000;
	localparam logic [WORD_W-1:0]  MID_CODE  = 24'h80_0000;
	localparam logic [WORD_W-1:0]  FS_NOM    = 24'h40_0000;

	// conversion periods per step
	localparam logic [2:0] SETTLE_PER = 3'h3;
	localparam logic [2:0] CAL_PER    = 3'h3;
	localparam logic [2:0] SYS_PER    = 3'h4;
	localparam logic [2:0] TAIL_PER   = 3'h1;

	typedef enum logic [2:0] {
		MODE_CONV  = 3'h0,
		MODE_SELF  = 3'h1,
		MODE_SOFF  = 3'h2,
		MODE_SPFS  = 3'h3,
		MODE_SNFS  = 3'h4,
		MODE_SOIG  = 3'h5,
		MODE_SGAIN = 3'h6,
		MODE_RSVD  = 3'h7
	} sdmc_mode_t;

	typedef enum logic [2:0] {
		FSEL_INPUT = 3'h0,
		FSEL_SHORT = 3'h1,
		FSEL_REFP  = 3'h2,
		FSEL_REFN  = 3'h3,
		FSEL_INREV = 3'h4
	} sdmc_fsel_t;

	localparam logic [1:0] COEF_OFF = 2'h0;
	localparam logic [1:0] COEF_POS = 2'h1;
	localparam logic [1:0] COEF_NEG = 2'h2;

	// host register map (APB byte addresses)
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_OFF    = 8'h04;
	localparam logic [7:0] REG_POS    = 8'h08;
	localparam logic [7:0] REG_NEG    = 8'h0C;
	localparam logic [7:0] REG_DATA   = 8'h10;
	localparam logic [7:0] REG_STATUS = 8'h14;
	localparam int CTRL_MODE_LSB  = 12;
	localparam int CTRL_UNITY_BIT = 15;
	localparam int ST_DATA_READY_N_BIT    = 0;
	localparam int ST_NEW_BIT     = 1;
	localparam int ST_ZERO_BIT    = 2;
	localparam int ST_STALE_BIT   = 3;
endpackage

// ==== sigma_delta_decimation_mode_control_tb.sv ====
// self-checking bench for the sigma-delta mode control
module sigma_delta_decimation_mode_control_tb
	import sdmc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int P = 512 * 10;
	logic        core_clk   = 1'b0;
	logic        rst        = 1'b1;
	logic [7:0]  paddr      = 8'h00;
	logic        psel       = 1'b0;
	logic        penable    = 1'b0;
	logic        pwrite     = 1'b0;
	logic        mod_bit_in = 1'b0;
	logic [31:0] pwdata     = 32'h0000_0000;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [8:0]  mcnt       = 9'h000;
	sdmc_fsel_t  front_sel;
	wire logic   rdy_n;
	int          mismatches = 0;
	int          num_checks = 0;

	sdmc_link_if sdmc_link_if_i ();
	assign rdy_n = sdmc_link_if_i.data_ready_n;
	sdmc_host_end sdmc_host_end_i (.core_clk(core_clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(sdmc_link_if_i));
	sdmc_dev_end sdmc_dev_end_i (.core_clk(core_clk), .rst(rst), .link(sdmc_link_if_i), .mod_bit_in(mod_bit_in),
		.front_sel(front_sel));
	sdmc_checker sdmc_checker_i (.core_clk(core_clk), .rst(rst), .notch_code(sdmc_link_if_i.notch_code),
		.operating_mode_select(sdmc_link_if_i.operating_mode_select), .mode_wr(sdmc_link_if_i.mode_wr),
		.coef_wr(sdmc_link_if_i.coef_wr), .coef_sel(sdmc_link_if_i.coef_sel), .data_ready_n(rdy_n),
		.result_stb(sdmc_link_if_i.result_stb), .result(sdmc_link_if_i.result), .off_coef(sdmc_link_if_i.off_coef),
		.pos_coef(sdmc_link_if_i.pos_coef), .neg_coef(sdmc_link_if_i.neg_coef));

	always #2.5 core_clk = ~core_clk;
	// modulator stream at three quarters ones, one bit per 128 clocks
	always @(posedge core_clk) begin
		mcnt <= mcnt + 9'h001;
		mod_bit_in <= (mcnt[8:7] != 2'b00);
	end

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cmp_flag(input logic got, input logic exp);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected flag at %0t: got %b expected %b", $time, got, exp);
		end
	endtask
	task automatic cmp_range(input int n, input int lo, input int hi);
		num_checks++;
		if (n < lo || n > hi) begin
			mismatches++;
			$display("unexpected cycle count at %0t: %0d not in %0d..%0d", $time, n, lo, hi);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
		output logic e);
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		psel <= 1'b1;
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		apb(1'b1, a, d, q, e);
		cmp_flag(e, 1'b0);
	endtask
	task automatic chk_rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		logic        e;
		apb(1'b0, a, 32'h0000_0000, q, e);
		cmp_val(q, exp);
		cmp_flag(e, 1'b0);
	endtask
	task automatic wait_stb(input int lim, output int n);
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (sdmc_link_if_i.result_stb !== 1'b1 && n < lim);
	endtask
	function automatic logic [31:0] ctrl(input sdmc_mode_t m, input logic [10:0] c);
		return {16'h0000, 1'b1, m, 1'b0, c};
	endfunction

	task automatic s_reset();
		logic [31:0] q;
		logic        e;
		chk_rd(REG_OFF, {8'h00, OFF_RST});
		chk_rd(REG_POS, {8'h00, GAIN_RST});
		chk_rd(REG_NEG, {8'h00, GAIN_RST});
		chk_rd(REG_STATUS, 32'h0000_0008);
		apb(1'b0, 8'h18, 32'h0000_0000, q, e);
		cmp_flag(e, 1'b1);
		apb(1'b1, 8'h02, 32'h0000_0000, q, e);
		cmp_flag(e, 1'b1);
	endtask
	task automatic s_conv();
		int n;
		wr(REG_CTRL, ctrl(MODE_CONV, NOTCH_MIN));
		repeat (2000) @(posedge core_clk);
		cmp_flag(rdy_n, 1'b1);
		// full scale before zero scale, code under floor
		wr(REG_CTRL, ctrl(MODE_SPFS, 11'h005));
		wait_stb(4 * P, n);
		cmp_range(n, 3 * P - 2, 3 * P + 8);
		cmp_flag(rdy_n, 1'b0);
		wait_stb(2 * P, n);
		cmp_range(n, P, P);
	endtask
	task automatic s_rsvd();
		int n;
		wr(REG_CTRL, ctrl(MODE_RSVD, NOTCH_MIN));
		wait_stb(2 * P, n);
		cmp_range(n, 2 * P, 2 * P);
		cmp_flag(rdy_n, 1'b1);
	endtask
	task automatic s_soff();
		int          n;
		logic [31:0] q;
		logic        e;
		wr(REG_CTRL, ctrl(MODE_SOFF, NOTCH_MIN));
		wait_stb(5 * P, n);
		cmp_range(n, 4 * P - 2, 4 * P + 8);
		cmp_flag(rdy_n, 1'b0);
		apb(1'b0, REG_OFF, 32'h0000_0000, q, e);
		cmp_flag(q[23:0] != OFF_RST, 1'b1);
		wr(REG_CTRL, ctrl(MODE_SPFS, NOTCH_MIN));
		repeat (2000) @(posedge core_clk);
		cmp_flag(rdy_n, 1'b1);
	endtask
	task automatic s_modes();
		wr(REG_CTRL, ctrl(MODE_SOIG, NOTCH_MIN) ^ 32'h0000_8000);
		chk_rd(REG_CTRL, 32'h0000_000A);
		wr(REG_CTRL, ctrl(MODE_SELF, NOTCH_MIN));
		@(posedge core_clk);
		cmp_val(32'(front_sel), 32'(FSEL_SHORT));
		wr(REG_CTRL, ctrl(MODE_SGAIN, NOTCH_MIN));
		@(posedge core_clk);
		cmp_val(32'(front_sel), 32'(FSEL_INPUT));
		chk_rd(REG_CTRL, ctrl(MODE_SGAIN, NOTCH_MIN));
		wr(REG_CTRL, ctrl(MODE_SNFS, NOTCH_MIN));
		chk_rd(REG_CTRL, ctrl(MODE_SNFS, NOTCH_MIN));
	endtask
	task automatic s_coef();
		int          n;
		logic [31:0] q;
		logic        e;
		wr(REG_CTRL, ctrl(MODE_CONV, NOTCH_MIN));
		wr(REG_OFF, {8'h00, OFF_RST});
		wr(REG_POS, {8'h00, GAIN_RST});
		wr(REG_NEG, {8'h00, GAIN_RST});
		wait_stb(4 * P, n);
		wait_stb(2 * P, n);
		cmp_range(n, P, P);
		chk_rd(REG_OFF, {8'h00, OFF_RST});
		chk_rd(REG_POS, {8'h00, GAIN_RST});
		chk_rd(REG_NEG, {8'h00, GAIN_RST});
		chk_rd(REG_STATUS, 32'h0000_0007);
		apb(1'b0, REG_DATA, 32'h0000_0000, q, e);
		cmp_flag(e, 1'b0);
		chk_rd(REG_STATUS, 32'h0000_0005);
	endtask

	initial begin
		repeat (90000) @(posedge core_clk);
		mismatches++;
		wrap_up();
	end
	initial begin
		repeat (12) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		s_reset();
		s_conv();
		s_rsvd();
		s_soff();
		s_modes();
		s_coef();
		wrap_up();
	end
endmodule
